/* include/flash_array_access_control_defs.vh */
// Functional notes
// - The single 64 KB array is organised as 1024 rows of 64 bytes each.
// - An erase sector is eight consecutive rows, that is 512 bytes.
// - Byte and aligned-word reads take one cycle; misaligned words take two.
// - Both a single-sector erase and a mass erase of the whole array exist.
// - Erased bits read as one and programmed bits read as zero.
// - No array data is returned to reads while a program or erase runs.
// - Commands are a write, a command code and a launch, in that order only.
// - Separate interrupts flag command completion and command buffer empty.
// - Program and erase timing is sequenced internally with no host help.
// - Programming is one word at a time; erasing is per sector or of the whole array.
// - Program or erase requests into protected regions are rejected.
// - Low and high protected regions are sizeable from 512 bytes to 4 KB.
`ifndef FLASH_ARRAY_ACCESS_CONTROL_DEFS_VH
`define FLASH_ARRAY_ACCESS_CONTROL_DEFS_VH

`define FL_ROWS 1024
`define FL_ROW_BYTES 64
`define FL_SECTOR_ROWS 8
`define FL_SECTOR_BYTES 512
`define FL_WORDS 32768
`define FL_WADDR_W 15
`define FL_SECT_LSB 8
`define FL_ERASED_WORD 16'hFFFF
`define FL_PROT_BASE 17'h0_0200
`define FL_ARRAY_TOP 17'h1_0000

`define FL_CMD_VERIFY 8'h01
`define FL_CMD_PROGRAM 8'h02
`define FL_CMD_SECT_ERASE 8'h03
`define FL_CMD_MASS_ERASE 8'h04

`define FL_CLK_MHZ 100
`define FL_TICK_NS 1000
`define FL_TICK_CYC ((`FL_TICK_NS * `FL_CLK_MHZ) / 1000)
`define FL_PROG_TIME_US 20
`define FL_ERASE_TIME_US 40

`endif

/* rtl/flash_cell_array.v */
`timescale 1ns/1ps
`default_nettype none
`include "flash_array_access_control_defs.vh"

module flash_cell_array (
    // Clock
    input wire clk_sys,
    // Word access
    input wire [`FL_WADDR_W-1:0] addr,
    input wire prog,
    input wire erase,
    input wire [15:0] wdata,
    output wire [15:0] rdata
);
    reg [15:0] cells [0:`FL_WORDS-1];

    assign rdata = cells[addr];

    always @(posedge clk_sys) begin
        if (erase) begin
            cells[addr] <= `FL_ERASED_WORD;
        end else if (prog) begin
            // Programming can only pull bits to zero
            cells[addr] <= cells[addr] & wdata;
        end
    end
endmodule // flash_cell_array

`default_nettype wire

/* rtl/flash_array_access_control.v */
`timescale 1ns/1ps
`default_nettype none
`include "flash_array_access_control_defs.vh"

module flash_array_access_control (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    // Array read port
    input wire rd_req,
    input wire [15:0] rd_addr,
    input wire rd_word,
    output wire rd_ready,
    output reg rd_valid_q,
    output reg [15:0] rd_data_q,
    output reg rd_blocked_q,
    // Command sequence port
    input wire cmd_wr,
    input wire [15:0] cmd_addr,
    input wire [15:0] cmd_data,
    input wire cmd_code_wr,
    input wire [7:0] cmd_code,
    input wire cmd_launch,
    input wire err_clr,
    // Protection setup
    input wire prot_lo_en,
    input wire [1:0] prot_lo_size,
    input wire prot_hi_en,
    input wire [1:0] prot_hi_size,
    // Interrupt enables
    input wire cbuf_empty_ie,
    input wire complete_ie,
    // Status
    output wire busy,
    output wire cbuf_empty,
    output wire complete,
    output reg seq_err_q,
    output reg prot_err_q,
    output reg blank_q,
    output wire irq_cbuf_empty,
    output wire irq_complete
);
    localparam ST_IDLE = 2'd0;
    localparam ST_TIME = 2'd1;
    localparam ST_PROG = 2'd2;
    localparam ST_SWEEP = 2'd3;
    localparam SQ_WRITE = 2'd0;
    localparam SQ_CODE = 2'd1;
    localparam SQ_LAUNCH = 2'd2;
    // Timer reloads, cut to the counter widths where they are used
    localparam [31:0] TICK_RELOAD = `FL_TICK_CYC - 1;
    localparam [31:0] PROG_WAIT = `FL_PROG_TIME_US;
    localparam [31:0] ERASE_WAIT = `FL_ERASE_TIME_US;

    function prot_hit;
        input [15:0] a;
        input lo_en;
        input [1:0] lo_sz;
        input hi_en;
        input [1:0] hi_sz;
        reg [16:0] lo_lim;
        reg [16:0] hi_base;
        begin
            lo_lim = `FL_PROT_BASE << lo_sz;
            hi_base = `FL_ARRAY_TOP - (`FL_PROT_BASE << hi_sz);
            prot_hit = (lo_en && ({1'b0, a} < lo_lim)) ||
                       (hi_en && ({1'b0, a} >= hi_base));
        end
    endfunction

    function code_ok;
        input [7:0] c;
        begin
            code_ok = (c == `FL_CMD_VERIFY) || (c == `FL_CMD_PROGRAM) ||
                      (c == `FL_CMD_SECT_ERASE) ||
                      (c == `FL_CMD_MASS_ERASE);
        end
    endfunction

    // Sequence capture and staged (second) command
    reg [1:0] seq_q;
    reg [15:0] seq_addr_q;
    reg [15:0] seq_data_q;
    reg [7:0] seq_code_q;
    reg stg_valid_q;
    reg [15:0] stg_addr_q;
    reg [15:0] stg_data_q;
    reg [7:0] stg_code_q;
    // Active command
    reg [1:0] st_q;
    reg [15:0] act_addr_q;
    reg [15:0] act_data_q;
    reg [7:0] act_code_q;
    reg [6:0] tick_cnt_q;
    reg [5:0] wait_q;
    reg [`FL_WADDR_W-1:0] idx_q;
    reg [`FL_WADDR_W-1:0] end_q;
    // Misaligned read second half
    reg mis_pend_q;
    reg [`FL_WADDR_W-1:0] mis_addr_q;
    reg [7:0] hold_q;

    reg [`FL_WADDR_W-1:0] mem_addr;
    reg seq_err_set;
    reg prot_err_set;
    wire [15:0] mem_rdata;
    wire mem_prog;
    wire mem_erase;
    wire tick;
    wire start;
    wire is_verify;

    assign busy = (st_q != ST_IDLE) || stg_valid_q;
    assign cbuf_empty = !stg_valid_q;
    assign complete = !busy;
    assign irq_cbuf_empty = cbuf_empty_ie && cbuf_empty;
    assign irq_complete = complete_ie && complete;
    assign rd_ready = !busy && !mis_pend_q;
    assign tick = (tick_cnt_q == 7'd0);
    assign start = (st_q == ST_IDLE) && stg_valid_q && !mis_pend_q;
    assign is_verify = (act_code_q == `FL_CMD_VERIFY);
    assign mem_prog = (st_q == ST_PROG);
    assign mem_erase = (st_q == ST_SWEEP) && !is_verify;

    always @* begin
        if (st_q == ST_SWEEP) begin
            mem_addr = idx_q;
        end else if (st_q == ST_PROG) begin
            mem_addr = act_addr_q[15:1];
        end else if (mis_pend_q) begin
            mem_addr = mis_addr_q;
        end else begin
            mem_addr = rd_addr[15:1];
        end
    end

    // Errors found on the command steps
    always @* begin
        seq_err_set = 1'b0;
        prot_err_set = 1'b0;
        if (cmd_launch) begin
            seq_err_set = (seq_q != SQ_LAUNCH) || cmd_wr || cmd_code_wr;
        end else if (cmd_code_wr) begin
            if ((seq_q != SQ_CODE) || cmd_wr || !code_ok(cmd_code)) begin
                seq_err_set = 1'b1;
            end else if ((cmd_code == `FL_CMD_PROGRAM) && seq_addr_q[0]) begin
                seq_err_set = 1'b1;
            end else if (((cmd_code == `FL_CMD_PROGRAM) ||
                          (cmd_code == `FL_CMD_SECT_ERASE)) &&
                         prot_hit(seq_addr_q, prot_lo_en, prot_lo_size,
                                  prot_hi_en, prot_hi_size)) begin
                prot_err_set = 1'b1;
            end else if ((cmd_code == `FL_CMD_MASS_ERASE) &&
                         (prot_lo_en || prot_hi_en)) begin
                prot_err_set = 1'b1;
            end
        end else if (cmd_wr) begin
            seq_err_set = (seq_q != SQ_WRITE) || stg_valid_q;
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            seq_q <= SQ_WRITE;
            seq_addr_q <= 16'h0000;
            seq_data_q <= 16'h0000;
            seq_code_q <= 8'h00;
            stg_valid_q <= 1'b0;
            stg_addr_q <= 16'h0000;
            stg_data_q <= 16'h0000;
            stg_code_q <= 8'h00;
            st_q <= ST_IDLE;
            act_addr_q <= 16'h0000;
            act_data_q <= 16'h0000;
            act_code_q <= 8'h00;
            tick_cnt_q <= 7'h00;
            wait_q <= 6'h00;
            idx_q <= 15'h0000;
            end_q <= 15'h0000;
            mis_pend_q <= 1'b0;
            mis_addr_q <= 15'h0000;
            hold_q <= 8'h00;
            rd_valid_q <= 1'b0;
            rd_data_q <= 16'h0000;
            rd_blocked_q <= 1'b0;
            seq_err_q <= 1'b0;
            prot_err_q <= 1'b0;
            blank_q <= 1'b0;
        end else begin
            // Sticky errors: a new error wins over a clear
            seq_err_q <= seq_err_set || (seq_err_q && !err_clr);
            prot_err_q <= prot_err_set || (prot_err_q && !err_clr);

            // Three-step command sequence
            if (seq_err_set || prot_err_set) begin
                seq_q <= SQ_WRITE;
            end else if (cmd_launch) begin
                seq_q <= SQ_WRITE;
                // Launch is dropped while an error is still flagged
                if (!seq_err_q && !prot_err_q) begin
                    stg_valid_q <= 1'b1;
                    stg_addr_q <= seq_addr_q;
                    stg_data_q <= seq_data_q;
                    stg_code_q <= seq_code_q;
                end
            end else if (cmd_code_wr) begin
                seq_code_q <= cmd_code;
                seq_q <= SQ_LAUNCH;
            end else if (cmd_wr) begin
                seq_addr_q <= cmd_addr;
                seq_data_q <= cmd_data;
                seq_q <= SQ_CODE;
            end

            // Microsecond tick for the internal timers
            if (tick) begin
                tick_cnt_q <= TICK_RELOAD[6:0];
            end else begin
                tick_cnt_q <= tick_cnt_q - 7'd1;
            end

            // Program and erase engine
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        stg_valid_q <= 1'b0;
                        act_addr_q <= stg_addr_q;
                        act_data_q <= stg_data_q;
                        act_code_q <= stg_code_q;
                        if (stg_code_q == `FL_CMD_SECT_ERASE) begin
                            idx_q <= {stg_addr_q[15:9], 8'h00};
                            end_q <= {stg_addr_q[15:9], 8'hFF};
                        end else begin
                            idx_q <= 15'h0000;
                            end_q <= 15'h7FFF;
                        end
                        if (stg_code_q == `FL_CMD_VERIFY) begin
                            blank_q <= 1'b1;
                            st_q <= ST_SWEEP;
                        end else if (stg_code_q == `FL_CMD_PROGRAM) begin
                            wait_q <= PROG_WAIT[5:0];
                            st_q <= ST_TIME;
                        end else begin
                            wait_q <= ERASE_WAIT[5:0];
                            st_q <= ST_TIME;
                        end
                    end
                end
                ST_TIME: begin
                    if (tick) begin
                        if (wait_q == 6'd1) begin
                            if (act_code_q == `FL_CMD_PROGRAM) begin
                                st_q <= ST_PROG;
                            end else begin
                                st_q <= ST_SWEEP;
                            end
                        end
                        wait_q <= wait_q - 6'd1;
                    end
                end
                ST_PROG: begin
                    st_q <= ST_IDLE;
                end
                ST_SWEEP: begin
                    if (is_verify && (mem_rdata != `FL_ERASED_WORD)) begin
                        blank_q <= 1'b0;
                    end
                    idx_q <= idx_q + 15'd1;
                    if (idx_q == end_q) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase

            // Read path
            rd_valid_q <= 1'b0;
            rd_blocked_q <= rd_req && busy && !mis_pend_q;
            if (mis_pend_q) begin
                mis_pend_q <= 1'b0;
                rd_valid_q <= 1'b1;
                rd_data_q <= {hold_q, mem_rdata[15:8]};
            end else if (rd_req && rd_ready) begin
                if (rd_word && rd_addr[0]) begin
                    hold_q <= mem_rdata[7:0];
                    mis_addr_q <= rd_addr[15:1] + 15'd1;
                    mis_pend_q <= 1'b1;
                end else if (rd_word) begin
                    rd_valid_q <= 1'b1;
                    rd_data_q <= mem_rdata;
                end else begin
                    rd_valid_q <= 1'b1;
                    rd_data_q <= {8'h00, rd_addr[0] ? mem_rdata[7:0] :
                                                     mem_rdata[15:8]};
                end
            end
        end
    end

    flash_cell_array u_cells (
        .clk_sys(clk_sys),
        .addr(mem_addr),
        .prog(mem_prog),
        .erase(mem_erase),
        .wdata(act_data_q),
        .rdata(mem_rdata)
    );
endmodule // flash_array_access_control

`default_nettype wire

/* bench/flash_array_access_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_array_access_control_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Read port
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    input wire logic rd_word,
    input wire logic rd_ready,
    input wire logic rd_valid_q,
    input wire logic rd_blocked_q,
    // Command port
    input wire logic cmd_wr,
    input wire logic cmd_code_wr,
    input wire logic cmd_launch,
    input wire logic err_clr,
    // Status
    input wire logic busy,
    input wire logic cbuf_empty,
    input wire logic complete,
    input wire logic seq_err_q,
    input wire logic prot_err_q,
    input wire logic complete_ie,
    input wire logic cbuf_empty_ie,
    input wire logic irq_complete,
    input wire logic irq_cbuf_empty
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_take_short;
        rd_req && rd_ready && !(rd_word && rd_addr[0]);
    endsequence
    sequence s_take_long;
        rd_req && rd_ready && rd_word && rd_addr[0];
    endsequence
    sequence s_cmd_ok;
        cmd_wr ##1 cmd_code_wr ##1 (cmd_launch && !seq_err_q && !prot_err_q);
    endsequence
    property p_short_read;
        s_take_short |=> rd_valid_q;
    endproperty
    a_short_read: assert property (p_short_read)
        else $error("short read not answered next cycle");
    property p_long_read;
        s_take_long |=> !rd_valid_q && !rd_ready ##1 rd_valid_q;
    endproperty
    a_long_read: assert property (p_long_read)
        else $error("misaligned read not answered in two cycles");
    property p_blocked;
        rd_req && busy |=> rd_blocked_q && !rd_valid_q;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("read during busy not blocked");
    property p_no_read_busy;
        busy |-> !rd_ready;
    endproperty
    a_no_read_busy: assert property (p_no_read_busy)
        else $error("read ready while busy");
    property p_launch;
        s_cmd_ok |=> busy && !cbuf_empty;
    endproperty
    a_launch: assert property (p_launch)
        else $error("good sequence not staged");
    property p_err_clr;
        err_clr && !cmd_wr && !cmd_code_wr && !cmd_launch
            |=> !seq_err_q && !prot_err_q;
    endproperty
    a_err_clr: assert property (p_err_clr)
        else $error("error flags not cleared");
    property p_err_sticky;
        seq_err_q && !err_clr |=> seq_err_q;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("sequence error dropped by itself");
    property p_done_irq;
        complete == !busy && irq_complete == (complete && complete_ie);
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("completion flag or interrupt wrong");
    property p_empty_irq;
        irq_cbuf_empty == (cbuf_empty && cbuf_empty_ie);
    endproperty
    a_empty_irq: assert property (p_empty_irq)
        else $error("buffer empty interrupt wrong");
endmodule // flash_array_access_control_props
bind flash_array_access_control flash_array_access_control_props u_props (
    .clk_sys, .srst, .rd_req, .rd_addr, .rd_word, .rd_ready, .rd_valid_q,
    .rd_blocked_q, .cmd_wr, .cmd_code_wr, .cmd_launch, .err_clr, .busy,
    .cbuf_empty, .complete, .seq_err_q, .prot_err_q, .complete_ie,
    .cbuf_empty_ie, .irq_complete, .irq_cbuf_empty
);
`default_nettype wire

/* bench/host_cmd_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
    // Clock
    input wire logic clk_sys,
    // Command steps
    output logic cmd_wr,
    output logic [15:0] cmd_addr,
    output logic [15:0] cmd_data,
    output logic cmd_code_wr,
    output logic [7:0] cmd_code,
    output logic cmd_launch
);
    initial begin
        cmd_wr = 0;
        cmd_addr = 16'h0000;
        cmd_data = 16'h0000;
        cmd_code_wr = 0;
        cmd_code = 8'h00;
        cmd_launch = 0;
    end
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask
    // Write, code, launch, one strobe per cycle
    task automatic issue(input logic [15:0] a, d, input logic [7:0] c);
        step;
        cmd_wr = 1;
        cmd_addr = a;
        cmd_data = d;
        step;
        cmd_wr = 0;
        cmd_code_wr = 1;
        cmd_code = c;
        step;
        cmd_code_wr = 0;
        cmd_launch = 1;
        step;
        cmd_launch = 0;
    endtask
    // Faulty host: code step without a preceding write
    task automatic code_only(input logic [7:0] c);
        step;
        cmd_code_wr = 1;
        cmd_code = c;
        step;
        cmd_code_wr = 0;
    endtask
endmodule // host_cmd_model
`default_nettype wire

/* bench/flash_array_access_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_array_access_control_defs.vh"
module flash_array_access_control_tb;
    logic clk_sys = 0, srst = 1, rd_req = 0, rd_word = 0, err_clr = 0;
    logic prot_lo_en = 0, prot_hi_en = 0, cbuf_empty_ie = 1, complete_ie = 1;
    logic [1:0] prot_lo_size = 2'h0, prot_hi_size = 2'h0;
    logic [15:0] rd_addr = 16'h0000;
    wire logic rd_ready, rd_valid_q, rd_blocked_q, busy, cbuf_empty, complete;
    wire logic seq_err_q, prot_err_q, blank_q, irq_cbuf_empty, irq_complete;
    wire logic cmd_wr, cmd_code_wr, cmd_launch;
    wire logic [15:0] rd_data_q, cmd_addr, cmd_data;
    wire logic [7:0] cmd_code;
    int n_fail = 0, comparisons = 0, cycles = 0;
    host_cmd_model host (.clk_sys(clk_sys), .cmd_wr(cmd_wr),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_code_wr(cmd_code_wr),
        .cmd_code(cmd_code), .cmd_launch(cmd_launch));
    flash_array_access_control uut (.clk_sys(clk_sys), .srst(srst),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_word(rd_word),
        .rd_ready(rd_ready), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
        .rd_blocked_q(rd_blocked_q), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_code_wr(cmd_code_wr), .cmd_code(cmd_code),
        .cmd_launch(cmd_launch), .err_clr(err_clr), .prot_lo_en(prot_lo_en),
        .prot_lo_size(prot_lo_size), .prot_hi_en(prot_hi_en),
        .prot_hi_size(prot_hi_size), .cbuf_empty_ie(cbuf_empty_ie),
        .complete_ie(complete_ie), .busy(busy), .cbuf_empty(cbuf_empty),
        .complete(complete), .seq_err_q(seq_err_q), .prot_err_q(prot_err_q),
        .blank_q(blank_q), .irq_cbuf_empty(irq_cbuf_empty),
        .irq_complete(irq_complete));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 40000 && busy !== 1'b0; i++) tick;
        check("complete", irq_complete, 1);
    endtask
    task automatic rd(input logic [15:0] a, input logic w,
        input logic [15:0] e);
        rd_req = 1;
        rd_addr = a;
        rd_word = w;
        tick;
        rd_req = 0;
        if (w && a[0]) tick;
        check("rd_valid", rd_valid_q, 1);
        check("rd_data", rd_data_q, e);
        // Let an edge pass so the next read starts from a low request
        tick;
    endtask
    task automatic t_erase_prog;
        host.issue(16'h0000, 16'h0000, `FL_CMD_MASS_ERASE);
        wait_idle;
        rd(16'h0010, 1, 16'hFFFF);
        rd(16'hFFFF, 1, 16'hFFFF);
        host.issue(16'h0010, 16'h12F0, `FL_CMD_PROGRAM);
        host.issue(16'h0200, 16'hABCD, `FL_CMD_PROGRAM);
        check("queued", cbuf_empty, 0);
        rd_req = 1;
        tick;
        rd_req = 0;
        check("blocked", rd_blocked_q, 1);
        wait_idle;
        rd(16'h0010, 1, 16'h12F0);
        rd(16'h0011, 0, 16'h00F0);
        rd(16'h0011, 1, 16'hF0FF);
        host.issue(16'h0000, 16'h0000, `FL_CMD_VERIFY);
        wait_idle;
        check("blank", blank_q, 0);
        host.issue(16'h0010, 16'h0000, `FL_CMD_SECT_ERASE);
        wait_idle;
        rd(16'h0010, 1, 16'hFFFF);
        rd(16'h0200, 1, 16'hABCD);
        $display("test erase_prog done");
    endtask
    task automatic clear;
        err_clr = 1;
        tick;
        err_clr = 0;
        check("flags", {seq_err_q, prot_err_q}, 0);
    endtask
    task automatic t_seq_err;
        host.code_only(`FL_CMD_PROGRAM);
        check("seq_err", seq_err_q, 1);
        host.issue(16'h0020, 16'h0000, `FL_CMD_PROGRAM);
        check("dropped", busy, 0);
        clear;
        complete_ie = 0;
        cbuf_empty_ie = 0;
        tick;
        check("irq_masked", {irq_complete, irq_cbuf_empty}, 0);
        complete_ie = 1;
        cbuf_empty_ie = 1;
        $display("test seq_err done");
    endtask
    task automatic t_prot(input logic lo, hi, input logic [1:0] sz,
        input logic [15:0] a, input logic [7:0] c, input logic e);
        prot_lo_en = lo;
        prot_hi_en = hi;
        prot_lo_size = sz;
        prot_hi_size = sz;
        host.issue(a, 16'h5A5A, c);
        check("prot_err", prot_err_q, e);
        check("started", busy, !e);
        wait_idle;
        clear;
        $display("test prot done");
    endtask
    initial begin
        repeat (4) tick;
        srst = 0;
        check("reset", {busy, cbuf_empty, irq_cbuf_empty}, 3'b011);
        t_erase_prog;
        t_seq_err;
        t_prot(1, 0, 2'h0, 16'h01FE, `FL_CMD_PROGRAM, 1);
        t_prot(1, 0, 2'h3, 16'h0FFE, `FL_CMD_PROGRAM, 1);
        t_prot(0, 1, 2'h0, 16'hFE00, `FL_CMD_SECT_ERASE, 1);
        t_prot(1, 0, 2'h0, 16'h0000, `FL_CMD_MASS_ERASE, 1);
        t_prot(0, 1, 2'h0, 16'hFDFE, `FL_CMD_PROGRAM, 0);
        complete_run;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 95000) begin
            n_fail++;
            complete_run;
        end
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
endmodule // flash_array_access_control_tb
`default_nettype wire
